// [rtl/lpddr_cmd_engine.sv]
/*
  Command decoder and bank state engine of an LPDDR2 die: auto precharge
  timing, burst terminate, all-bank refresh and self-refresh.
  Assumes the controller keeps all spacing rules; inputs are synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Read AP precharges after max(BL/2, tRTP)
// - Write AP precharges tWR after last data
// - Other-bank commands accepted during auto precharge
// - Precharges back to back; tRP from latest
// - Decode terminate; affects latest burst only
// - Terminate ends burst RL or WL later
// - Decode refresh; CA3 selects all banks
// - All-bank refresh uses counter, leaves idle
// - Decode self-refresh entry on CKE fall
// - Refresh internally within tCKE of entry
module lpddr_cmd_engine (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire lpddr_cmd_pkg::ca_bus_s ca,
  output var  lpddr_cmd_pkg::status_s status,
  output logic                       data_valid,
  output logic                       data_is_write,
  output logic [2:0]                 refresh_bank
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [2:0] bank_of(input logic [9:0] r);
    bank_of = {r[9], r[8], r[7]};
  endfunction : bank_of

  function automatic lpddr_cmd_pkg::cmd_e decode(
    input lpddr_cmd_pkg::ca_bus_s c, input logic cke_prev);
    decode = lpddr_cmd_pkg::CMD_NONE;
    if (!c.cs_n) begin
      if (cke_prev && !c.cke) begin
        if (c.ca_r[2:0] == 3'h4)
          decode = lpddr_cmd_pkg::CMD_SREF;
      end else if (c.cke) begin
        if (c.ca_r[1:0] == 2'h2)
          decode = lpddr_cmd_pkg::CMD_ACT;
        else if (c.ca_r[2:0] == 3'h7)
          decode = lpddr_cmd_pkg::CMD_NONE;
        else if (c.ca_r[2:0] == 3'h3 && c.ca_r[3])
          decode = lpddr_cmd_pkg::CMD_PRE;
        else if (c.ca_r[3:0] == 4'h3)
          decode = lpddr_cmd_pkg::CMD_BST;
        else if (c.ca_r[2:0] == 3'h4)
          decode = lpddr_cmd_pkg::CMD_REF;
        else if (c.ca_r[2:0] == 3'h5)
          decode = lpddr_cmd_pkg::CMD_READ;
        else if (c.ca_r[2:0] == 3'h1)
          decode = lpddr_cmd_pkg::CMD_WRITE;
      end
    end
  endfunction : decode

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    lpddr_cmd_pkg::mode_e mode;
    logic                 cke_prev;
    logic [7:0]           open_banks;
    logic [7:0]           ap_pend;
    logic [7:0][5:0]      ap_cnt;
    logic [7:0][5:0]      rp_cnt;
    logic [15:0]          sched;
    logic                 burst_wr;
    logic [2:0]           burst_bank;
    logic                 burst_ap;
    logic [11:0]          timer;
    logic [2:0]           ref_bank;
    logic                 int_ref;
    logic                 data_valid;
  } state_s;

  state_s q, d;
  lpddr_cmd_pkg::cmd_e cmd;

  localparam logic [5:0] HALF_BL = 6'(lpddr_cmd_pkg::BURST_LEN / 2);
  localparam logic [5:0] RD_AP   = 6'(lpddr_cmd_pkg::RD_AP_CYC);
  localparam logic [5:0] WR_AP   = 6'(int'(lpddr_cmd_pkg::WRITE_LAT)
    + lpddr_cmd_pkg::BURST_LEN / 2 + lpddr_cmd_pkg::WR_CYC);
  localparam logic [15:0] BEATS  =
    16'((1 << (lpddr_cmd_pkg::BURST_LEN / 2)) - 1);
  localparam logic [15:0] RD_SCHED = BEATS << lpddr_cmd_pkg::READ_LAT;
  localparam logic [15:0] WR_SCHED = BEATS << lpddr_cmd_pkg::WRITE_LAT;
  localparam logic [15:0] RD_KEEP  =
    (16'h0001 << lpddr_cmd_pkg::READ_LAT) - 16'h0001;
  localparam logic [15:0] WR_KEEP  =
    (16'h0001 << lpddr_cmd_pkg::WRITE_LAT) - 16'h0001;
  localparam logic [5:0] RP      = 6'(lpddr_cmd_pkg::RP_CYC);
  localparam logic [11:0] RFC    = 12'(lpddr_cmd_pkg::RFC_CYC);
  localparam logic [11:0] CKE_T  = 12'(lpddr_cmd_pkg::CKE_CYC);

  always_comb begin
    cmd = decode(ca, q.cke_prev);
    d = q;
    d.cke_prev = ca.cke;
    d.int_ref = 1'b0;

    // Bank timers: auto precharge countdown then tRP
    for (int b = 0; b < 8; b++) begin
      if (q.ap_pend[b]) begin
        if (q.ap_cnt[b] <= 6'h01) begin
          d.ap_pend[b]    = 1'b0;
          d.open_banks[b] = 1'b0;
          d.rp_cnt[b]     = RP;
        end else begin
          d.ap_cnt[b] = q.ap_cnt[b] - 6'h01;
        end
      end else if (q.rp_cnt[b] != 6'h00) begin
        d.rp_cnt[b] = q.rp_cnt[b] - 6'h01;
      end
    end

    // Data beats: one bit per coming cycle, so bursts run back to back
    d.data_valid = q.sched[0];
    d.sched      = q.sched >> 1;

    case (q.mode)
      lpddr_cmd_pkg::ST_ACTIVE: begin
        case (cmd)
          lpddr_cmd_pkg::CMD_ACT: begin
            d.open_banks[bank_of(ca.ca_r)] = 1'b1;
          end
          lpddr_cmd_pkg::CMD_READ,
          lpddr_cmd_pkg::CMD_WRITE: begin
            // Other banks keep their own auto precharge timers
            d.burst_wr   = (cmd == lpddr_cmd_pkg::CMD_WRITE);
            d.burst_bank = bank_of(ca.ca_r);
            d.burst_ap   = ca.ca_f[0];
            d.sched      = d.sched | (d.burst_wr ? WR_SCHED : RD_SCHED);
            if (ca.ca_f[0]) begin
              d.ap_pend[bank_of(ca.ca_r)] = 1'b1;
              d.ap_cnt[bank_of(ca.ca_r)]  = d.burst_wr ? WR_AP : RD_AP;
            end
          end
          lpddr_cmd_pkg::CMD_PRE: begin
            for (int b = 0; b < 8; b++) begin
              if (ca.ca_r[4] || bank_of(ca.ca_r) == 3'(b)) begin
                d.open_banks[b] = 1'b0;
                d.ap_pend[b]    = 1'b0;
                d.rp_cnt[b]     = RP;
              end
            end
          end
          lpddr_cmd_pkg::CMD_BST: begin
            // Cut the latest burst, only when auto precharge is off
            if (q.sched != 16'h0000 && !q.burst_ap) begin
              d.sched = d.sched & (q.burst_wr ? WR_KEEP : RD_KEEP);
            end
          end
          lpddr_cmd_pkg::CMD_REF: begin
            if (ca.ca_r[3]) begin
              d.mode  = lpddr_cmd_pkg::ST_REFRESH;
              d.timer = RFC;
              d.int_ref = 1'b1;
            end
          end
          lpddr_cmd_pkg::CMD_SREF: begin
            d.mode    = lpddr_cmd_pkg::ST_SELF;
            d.timer   = CKE_T;
            d.int_ref = 1'b1;
          end
          default: begin
          end
        endcase
      end
      lpddr_cmd_pkg::ST_REFRESH: begin
        d.ref_bank = q.ref_bank + 3'h1;
        if (q.timer <= 12'h001) begin
          d.timer = 12'h000;
          d.open_banks = 8'h00;
          d.mode = lpddr_cmd_pkg::ST_ACTIVE;
        end else begin
          d.timer = q.timer - 12'h001;
        end
      end
      lpddr_cmd_pkg::ST_SELF: begin
        if (q.timer != 12'h000) begin
          d.timer = q.timer - 12'h001;
          d.ref_bank = q.ref_bank + 3'h1;
        end
        if (ca.cke && q.timer == 12'h000) begin
          d.mode = lpddr_cmd_pkg::ST_ACTIVE;
        end
      end
      default: d.mode = lpddr_cmd_pkg::ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.mode <= lpddr_cmd_pkg::ST_ACTIVE;
      q.open_banks <= lpddr_cmd_pkg::BANKS_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic                   dw_q;
  lpddr_cmd_pkg::status_s st_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
      dw_q <= 1'b0;
    end else begin
      st_q.open_banks  <= d.open_banks;
      st_q.precharging <= d.ap_pend;
      st_q.burst_busy  <= d.sched != 16'h0000;
      st_q.in_self     <= d.mode == lpddr_cmd_pkg::ST_SELF;
      st_q.refreshing  <= d.mode != lpddr_cmd_pkg::ST_ACTIVE;
      st_q.int_refresh <= d.int_ref;
      dw_q             <= d.burst_wr;
    end
  end

  assign status        = st_q;
  assign data_valid    = q.data_valid;
  assign data_is_write = dw_q;
  assign refresh_bank  = q.ref_bank;

endmodule : lpddr_cmd_engine

`default_nettype wire

// [rtl/lpddr_cmd_pkg.sv]
/*
  Shared constants and types for the SDRAM command engine: command codes,
  latencies, timing figures and the packed carriers between files.
  Assumes a single 10 MHz clock; times are rounded to whole cycles here.
*/
package lpddr_cmd_pkg;

  // ----------------------------------------------------------------------
  // Geometry and latencies
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_BANKS   = 8;
  localparam int unsigned BURST_LEN   = 8;
  localparam logic [3:0]  READ_LAT    = 4'h3;
  localparam logic [3:0]  WRITE_LAT   = 4'h1;
  localparam int unsigned CLK_PERIOD_NS = 100;

  // ----------------------------------------------------------------------
  // Timing in nanoseconds and derived cycle counts
  // ----------------------------------------------------------------------
  localparam int unsigned T_RTP_NS  = 8;
  localparam int unsigned T_WR_NS   = 15;
  localparam int unsigned T_RP_NS   = 18;
  localparam int unsigned T_RFC_NS  = 130;
  localparam int unsigned T_CKE_NS  = 300;
  localparam int unsigned T_REFI_NS = 3900;

  localparam int unsigned RTP_CYC  =
    (T_RTP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_CYC   =
    (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RP_CYC   =
    (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RFC_CYC  =
    (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CKE_CYC  =
    (T_CKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REFI_CYC =
    (T_REFI_NS / CLK_PERIOD_NS) > 0 ? T_REFI_NS / CLK_PERIOD_NS : 1;

  // Auto precharge delay after a read: larger of BL/2 and tRTP
  localparam int unsigned RD_AP_CYC =
    (BURST_LEN / 2) > RTP_CYC ? BURST_LEN / 2 : RTP_CYC;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] BANKS_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE, CMD_READ, CMD_WRITE, CMD_PRE, CMD_BST, CMD_REF, CMD_SREF,
    CMD_ACT
  } cmd_e;

  typedef enum logic [1:0] { ST_ACTIVE, ST_SELF, ST_REFRESH } mode_e;

  typedef struct packed {
    logic       cs_n;
    logic       cke;
    logic [9:0] ca_r;
    logic [9:0] ca_f;
  } ca_bus_s;

  typedef struct packed {
    logic [7:0] open_banks;
    logic [7:0] precharging;
    logic       burst_busy;
    logic       in_self;
    logic       refreshing;
    logic       int_refresh;
  } status_s;

endpackage : lpddr_cmd_pkg

// [verification/lpddr_host_model.sv]
/*
  Controller model that drives the command bus of the engine.
  Assumes callers resume 1 ns after a rising edge, as this task does.
*/
`timescale 1ns/1ps
`default_nettype none
module lpddr_host_model (
  input  wire logic             clk,
  output var lpddr_cmd_pkg::ca_bus_s ca
);
  initial ca = '{cs_n: 1'b1, cke: 1'b1, ca_r: 10'h000, ca_f: 10'h000};

  // One command, gap edges after the previous one, then deselect
  task automatic cmd(input logic [9:0] r, input logic [9:0] f,
                     input logic cke, input int gap);
    repeat (gap - 1) begin
      @(posedge clk);
      #1;
    end
    ca.cs_n = 1'b0;
    ca.cke  = cke;
    ca.ca_r = r;
    ca.ca_f = f;
    @(posedge clk);
    #1;
    ca.cs_n = 1'b1;
    ca.ca_r = ~r;
    ca.ca_f = ~f;
  endtask : cmd
endmodule : lpddr_host_model
`default_nettype wire

// [verification/lpddr_cmd_engine_asserts.sv]
/*
  Port checker for the command engine.
  Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module lpddr_cmd_engine_asserts (
  input wire logic                   clk,
  input wire logic                   reset,
  input wire lpddr_cmd_pkg::ca_bus_s ca,
  input wire lpddr_cmd_pkg::status_s status,
  input wire logic                   data_valid,
  input wire logic                   data_is_write,
  input wire logic [2:0]             refresh_bank
);
  logic cke_q;
  logic live;
  logic rd;
  logic wr;
  logic bst;
  logic rfa;
  logic sr;

  always_ff @(posedge clk) cke_q <= ca.cke;
  assign live = !ca.cs_n && ca.cke && !status.in_self && !status.refreshing;
  assign rd   = live && ca.ca_r[2:0] == 3'h5;
  assign wr   = live && ca.ca_r[2:0] == 3'h1;
  assign bst  = live && ca.ca_r[3:0] == 4'h3;
  assign rfa  = live && ca.ca_r[3:0] == 4'hc;
  assign sr   = !ca.cs_n && !ca.cke && cke_q && ca.ca_r[2:0] == 3'h4
                && !status.in_self && !status.refreshing;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_read_ap_flag: assert property (
    rd && ca.ca_f[0] |=> status.precharging[$past(ca.ca_r[9:7])])
    else $error("auto precharge not pending");
  a_read_ap_close: assert property (
    rd && ca.ca_f[0] |-> ##4 status.precharging[$past(ca.ca_r[9:7], 4)]
    ##1 !status.open_banks[$past(ca.ca_r[9:7], 5)])
    else $error("auto precharge at wrong edge");
  a_read_data: assert property (
    rd && !status.burst_busy && !data_valid |-> ##5 data_valid [*2])
    else $error("read data late");
  a_write_data: assert property (
    wr && !status.burst_busy && !data_valid |-> ##3 data_valid && data_is_write)
    else $error("write data late");
  a_bst_read_cut: assert property (
    (rd && !status.burst_busy && !ca.ca_f[0]) ##2 bst
    |-> ##3 data_valid ##1 data_valid ##1 !data_valid)
    else $error("read not cut");
  a_bst_write_cut: assert property (
    (wr && !status.burst_busy && !ca.ca_f[0]) ##2 bst
    |-> ##1 data_valid ##1 data_valid ##1 !data_valid)
    else $error("write not cut");
  a_ref_start: assert property (
    rfa |=> status.refreshing && status.int_refresh)
    else $error("refresh not started");
  a_ref_idle: assert property (
    status.refreshing && !status.in_self |-> status.open_banks == 8'h00)
    else $error("bank open in refresh");
  a_sref_enter: assert property (
    sr |=> status.in_self) else $error("self refresh not entered");
  a_sref_refresh: assert property (
    sr |-> ##[1:3] status.int_refresh) else $error("no internal refresh");
  a_sref_hold: assert property (
    status.in_self && !ca.cke |=> status.in_self)
    else $error("left self refresh early");
  a_pulse_once: assert property (
    status.int_refresh |=> !status.int_refresh) else $error("pulse too long");
endmodule : lpddr_cmd_engine_asserts

bind lpddr_cmd_engine lpddr_cmd_engine_asserts chk (.clk(clk),
  .reset(reset), .ca(ca), .status(status), .data_valid(data_valid),
  .data_is_write(data_is_write), .refresh_bank(refresh_bank));
`default_nettype wire

// [verification/lpddr_autopre_bst_refresh_bench.sv]
/*
  Self-checking bench for the command engine with a controller model.
  Assumes a 10 MHz clock and the latencies of the shared package.
*/
`timescale 1ns/1ps
`default_nettype none
module lpddr_autopre_bst_refresh_bench;
  logic                   clk = 1'b0;
  logic                   reset = 1'b1;
  lpddr_cmd_pkg::ca_bus_s ca;
  lpddr_cmd_pkg::status_s status;
  logic                   data_valid;
  logic                   data_is_write;
  logic [2:0]             refresh_bank;
  int                     fail_count = 0;
  int                     samples_checked = 0;
  int                     beat_n = 0;

  lpddr_host_model host (.clk(clk), .ca(ca));
  lpddr_cmd_engine dut (.clk(clk), .reset(reset), .ca(ca),
    .status(status), .data_valid(data_valid),
    .data_is_write(data_is_write), .refresh_bank(refresh_bank));

  always #50 clk = ~clk;
  always @(posedge clk) beat_n <= beat_n + int'(data_valid === 1'b1);

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      fail_count++;
    end
  endtask : check

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : idle

  function automatic logic [9:0] op(input logic [2:0] b, input logic [3:0] c);
    return {b, 3'h0, c};
  endfunction : op

  task automatic read_ap;
    host.cmd(op(3'h2, 4'h2), 10'h000, 1'b1, 1);
    beat_n = 0;
    host.cmd(op(3'h2, 4'h5), 10'h001, 1'b1, 3);
    check(status.precharging, 8'h04, "pending");
    idle(10);
    check(8'(beat_n), 8'h04, "read beats");
    check(status.open_banks, 8'h00, "closed");
  endtask : read_ap

  task automatic concurrent;
    host.cmd(op(3'h1, 4'h2), 10'h000, 1'b1, 1);
    host.cmd(op(3'h4, 4'h2), 10'h000, 1'b1, 1);
    beat_n = 0;
    host.cmd(op(3'h1, 4'h5), 10'h001, 1'b1, 3);
    host.cmd(op(3'h4, 4'h5), 10'h000, 1'b1, 4);
    idle(14);
    check(8'(beat_n), 8'h08, "seamless beats");
    check(status.open_banks, 8'h10, "other bank");
  endtask : concurrent

  task automatic write_ap;
    host.cmd(op(3'h3, 4'h2), 10'h000, 1'b1, 1);
    beat_n = 0;
    host.cmd(op(3'h3, 4'h1), 10'h001, 1'b1, 3);
    idle(10);
    check(8'(beat_n), 8'h04, "write beats");
    check(status.open_banks, 8'h10, "write closed");
  endtask : write_ap

  task automatic terminate;
    host.cmd(op(3'h5, 4'h2), 10'h000, 1'b1, 1);
    beat_n = 0;
    host.cmd(op(3'h5, 4'h5), 10'h000, 1'b1, 3);
    host.cmd(op(3'h0, 4'h3), 10'h000, 1'b1, 2);
    idle(8);
    check(8'(beat_n), 8'h02, "read cut");
    beat_n = 0;
    host.cmd(op(3'h5, 4'h1), 10'h000, 1'b1, 6);
    host.cmd(op(3'h0, 4'h3), 10'h000, 1'b1, 2);
    idle(8);
    check(8'(beat_n), 8'h02, "write cut");
    check(8'(data_is_write), 8'h01, "burst kind");
    host.cmd(op(3'h5, 4'hb), 10'h000, 1'b1, 6);
    host.cmd(op(3'h0, 4'hb) | 10'h010, 10'h000, 1'b1, 1);
    idle(2);
    check(status.open_banks, 8'h00, "all closed");
  endtask : terminate

  task automatic refresh;
    host.cmd(op(3'h0, 4'hc), 10'h000, 1'b1, 4);
    check(8'(status.refreshing), 8'h01, "refreshing");
    check(8'(status.int_refresh), 8'h01, "refresh pulse");
    host.cmd(op(3'h0, 4'h2), 10'h000, 1'b1, 1);
    idle(4);
    check(status.open_banks, 8'h00, "idle after");
  endtask : refresh

  task automatic self_refresh;
    host.cmd(op(3'h0, 4'h4), 10'h000, 1'b0, 2);
    check(8'(status.in_self), 8'h01, "entered");
    check(8'(status.int_refresh), 8'h01, "inner refresh");
    host.cmd(op(3'h6, 4'h2), 10'h000, 1'b0, 2);
    host.cmd(op(3'h0, 4'h7), 10'h000, 1'b1, 4);
    idle(3);
    check(8'(status.in_self), 8'h00, "exited");
    check(status.open_banks, 8'h00, "ignored");
    host.cmd(op(3'h0, 4'hc), 10'h000, 1'b1, 2);
    idle(4);
  endtask : self_refresh

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    read_ap();
    concurrent();
    write_ap();
    terminate();
    refresh();
    self_refresh();
    stop_test();
  end

  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
endmodule : lpddr_autopre_bst_refresh_bench
`default_nettype wire
